//--- core/rii_top.sv
`timescale 1ns/10ps
//
// Contract
// - thirty-two integration words kept apart from the display words.
// - integrate 8 sweeps at low rate, 16 sweeps at high rate.
// - eight-bit accumulator cleared at the reset count of each cycle.
// - level load captures encoder code and fetches stored sum together.
// - first sweep of a period uses zero as the stored sum.
// - add strobe sums; complement result gated by integrate pulse.
// - all data pass common write gating; sum written back with strobe.
// - word bits 7..4 data, 3..2 unused, 1..0 flags.
// - printed flag set after print; dimension flag blocks new dimensions.
// - store intensity reads display word, ORs flags; clear flags allow.
// - sum fetched at count 6, bits 7..4 written at count 13.
// - average drops four low bits at high rate, three at low.
// - set flag inhibits fetch and write, existing word kept.
// - dimension record is letter, tens, units, one word at a time.
// - azimuth or range select and first/second/third word selects.
// - dimension store reads at count 2, samples flags at count 6.
// - count 8 writes dimension word and advances word selection.
// - print loads bits 7..4, decodes to exactly one character line.
// - encoder gives code of highest of ten thresholds, then resets.
// - store follows integrate for one sweep: intensity then dimension.
module rii_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // avalon-mm slave
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // radar pins
    input wire logic sweep_i,
    input wire logic [9:0] thresh_hit_i,
    // dimension source selects
    output logic azimuth_sel_o,
    output logic range_sel_o,
    output logic [2:0] word_sel_o,
    output logic advance_o,
    // memory strobes and character generator
    output logic memory_read_strobe_o,
    output logic memory_write_strobe_o,
    output logic [15:0] char_sel_o
);

    logic [7:0] integ_mem [rii_pkg::SLOTS];
    logic [7:0] disp_mem [rii_pkg::SLOTS];
    rii_pkg::rii_phase_e phase_r;
    logic busy_r, first_r, inhibit_r, pr_valid_r;
    logic [4:0] tcnt_r, slot_r, sweeps_r, sweeps_nxt, target;
    logic [7:0] acc_r, fetch_r, sum_r, mir_r;
    logic [3:0] lvl_r, hold_r, enc_code, avg, dim_word;
    logic [9:0] thr_s1_r, thr_s2_r, peak_r;
    logic sw_s1_r, sw_s2_r, sw_s3_r, sweep_edge;
    logic run_r, rate_r, dpend_r, drng_r;
    logic [4:0] dim_base_r, disp_ptr_r, addr;
    logic [3:0] tens_r, units_r;
    logic [2:0] word_sel_r;
    logic advance_r, rd_stb_r, wr_stb_r, az_r, rg_r;
    logic [15:0] char_sel_r;
    logic [31:0] rdata_r;
    logic wait_r, bus_ack, last_cnt, pass_last, pass_end;
    logic integ, sti, std, prt;
    logic wr_int, wr_si, wr_dm, wr_pr, rd_now;
    logic [7:0] acc_cmp, gate_data, keep_word;

    // pin synchronisers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            thr_s1_r <= '0;
            thr_s2_r <= '0;
            sw_s1_r <= 1'b0;
            sw_s2_r <= 1'b0;
            sw_s3_r <= 1'b0;
        end else begin
            thr_s1_r <= thresh_hit_i;
            thr_s2_r <= thr_s1_r;
            sw_s1_r <= sweep_i;
            sw_s2_r <= sw_s1_r;
            sw_s3_r <= sw_s2_r;
        end
    end
    assign sweep_edge = sw_s2_r & ~sw_s3_r;

    assign integ = (phase_r == rii_pkg::PH_INTEG);
    assign sti = (phase_r == rii_pkg::PH_STI);
    assign std = (phase_r == rii_pkg::PH_STD);
    assign prt = (phase_r == rii_pkg::PH_PRINT);
    assign last_cnt = (tcnt_r == rii_pkg::T_LAST);
    assign pass_last = std ? (slot_r == rii_pkg::DIM_LAST)
                           : (slot_r == rii_pkg::SLOT_LAST);
    assign pass_end = busy_r & last_cnt & pass_last;
    assign target = rate_r ? rii_pkg::SWEEPS_HIGH
                           : rii_pkg::SWEEPS_LOW;
    assign sweeps_nxt = sweeps_r + 5'h01;

    // peak of thresholds crossed since the last level load
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            peak_r <= '0;
        end else if (busy_r && integ && tcnt_r == rii_pkg::T_LOAD) begin
            peak_r <= thr_s2_r;
        end else begin
            peak_r <= peak_r | thr_s2_r;
        end
    end

    // highest level exceeded, 1..10, zero for none
    always_comb begin
        enc_code = 4'h0;
        for (int i = 0; i < rii_pkg::THRESH; i++) begin
            if (peak_r[i]) begin
                enc_code = 4'(i + 1);
            end
        end
    end

    // phase and memory timing sequencer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_r <= rii_pkg::PH_IDLE;
            busy_r <= 1'b0;
            first_r <= 1'b1;
            tcnt_r <= '0;
            slot_r <= '0;
            sweeps_r <= '0;
        end else if (!run_r) begin
            phase_r <= rii_pkg::PH_IDLE;
            busy_r <= 1'b0;
        end else if (phase_r == rii_pkg::PH_IDLE) begin
            phase_r <= rii_pkg::PH_INTEG;
            first_r <= 1'b1;
            sweeps_r <= '0;
        end else if (!busy_r) begin
            if (sweep_edge) begin
                busy_r <= 1'b1;
                tcnt_r <= '0;
                slot_r <= '0;
            end
        end else if (!last_cnt) begin
            tcnt_r <= tcnt_r + 5'h01;
        end else if (!pass_last) begin
            tcnt_r <= '0;
            slot_r <= slot_r + 5'h01;
        end else begin
            tcnt_r <= '0;
            slot_r <= '0;
            busy_r <= 1'b0;
            case (phase_r)
                rii_pkg::PH_INTEG: begin
                    first_r <= 1'b0;
                    sweeps_r <= sweeps_nxt;
                    if (sweeps_nxt == target) begin
                        phase_r <= rii_pkg::PH_STI;
                    end
                end
                rii_pkg::PH_STI: begin
                    if (dpend_r) begin
                        phase_r <= rii_pkg::PH_STD;
                        busy_r <= 1'b1;
                    end else begin
                        phase_r <= rii_pkg::PH_PRINT;
                    end
                end
                rii_pkg::PH_STD: begin
                    phase_r <= rii_pkg::PH_PRINT;
                end
                rii_pkg::PH_PRINT: begin
                    phase_r <= rii_pkg::PH_INTEG;
                    first_r <= 1'b1;
                    sweeps_r <= '0;
                end
                default: begin
                    phase_r <= rii_pkg::PH_IDLE;
                end
            endcase
        end
    end

    // accumulator and integration datapath
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            acc_r <= '0;
            lvl_r <= '0;
            fetch_r <= '0;
        end else if (busy_r && integ) begin
            if (tcnt_r == rii_pkg::T_RST) begin
                acc_r <= '0;
            end
            if (tcnt_r == rii_pkg::T_LOAD) begin
                lvl_r <= enc_code;
                fetch_r <= first_r ? 8'h00 : integ_mem[slot_r];
            end
            if (tcnt_r == rii_pkg::T_ADD) begin
                acc_r <= fetch_r + {4'h0, lvl_r};
            end
        end
    end

    // display word fetch, flag sampling and print holding register
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mir_r <= '0;
            inhibit_r <= 1'b0;
            sum_r <= '0;
            hold_r <= '0;
            pr_valid_r <= 1'b0;
        end else begin
            if (busy_r && !integ && tcnt_r == rii_pkg::T_RD) begin
                mir_r <= disp_mem[addr];
            end
            if (busy_r && ((sti && tcnt_r == rii_pkg::T_SI_SAMP) ||
                           (std && tcnt_r == rii_pkg::T_DM_SAMP))) begin
                inhibit_r <= mir_r[rii_pkg::B_PRINTED] |
                             mir_r[rii_pkg::B_DIM];
            end
            if (busy_r && sti && !inhibit_r &&
                tcnt_r == rii_pkg::T_SI_FETCH) begin
                sum_r <= integ_mem[slot_r];
            end
            if (busy_r && prt && tcnt_r == rii_pkg::T_PR_LOAD) begin
                hold_r <= mir_r[7:4];
                pr_valid_r <= 1'b1;
            end else if (!prt) begin
                pr_valid_r <= 1'b0;
            end
        end
    end

    assign avg = rate_r ? sum_r[7:4] : sum_r[6:3];
    assign acc_cmp = ~acc_r;
    assign dim_word = word_sel_r[0] ? (drng_r ? rii_pkg::LETTER_RG
                                              : rii_pkg::LETTER_AZ)
                    : word_sel_r[1] ? tens_r : units_r;
    assign addr = std ? (dim_base_r + slot_r) : slot_r;

    // common write gating for every source
    assign wr_int = busy_r && integ && tcnt_r == rii_pkg::T_IWR;
    assign wr_si = busy_r && sti && !inhibit_r &&
                   tcnt_r == rii_pkg::T_SI_WR;
    assign wr_dm = busy_r && std && !inhibit_r &&
                   tcnt_r == rii_pkg::T_DM_WR;
    assign wr_pr = busy_r && prt && tcnt_r == rii_pkg::T_PR_MARK;
    assign rd_now = busy_r && ((integ && tcnt_r == rii_pkg::T_LOAD) ||
                    (!integ && tcnt_r == rii_pkg::T_RD) ||
                    (sti && !inhibit_r &&
                     tcnt_r == rii_pkg::T_SI_FETCH));

    always_comb begin
        gate_data = 8'h00;
        case (phase_r)
            rii_pkg::PH_INTEG: gate_data = ~(acc_cmp | {8{~wr_int}});
            rii_pkg::PH_STI: gate_data = {avg, 4'h0};
            rii_pkg::PH_STD: gate_data = {dim_word, rii_pkg::UNUSED_BITS,
                                          rii_pkg::FLAGS_DIM};
            rii_pkg::PH_PRINT: gate_data = mir_r | 8'h01;
            default: gate_data = 8'h00;
        endcase
    end

    // buffer memory: integration area and display area
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < rii_pkg::SLOTS; i++) begin
                integ_mem[i] <= 8'h00;
                disp_mem[i] <= 8'h00;
            end
        end else begin
            if (wr_int) begin
                integ_mem[slot_r] <= gate_data;
            end
            if (wr_si || wr_dm || wr_pr) begin
                disp_mem[addr] <= gate_data;
            end
        end
    end
    assign keep_word = disp_mem[slot_r];

    // dimension word selection and source selects
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            word_sel_r <= 3'h1;
            advance_r <= 1'b0;
            az_r <= 1'b0;
            rg_r <= 1'b0;
        end else begin
            advance_r <= busy_r && std && tcnt_r == rii_pkg::T_DM_WR;
            if (!std) begin
                word_sel_r <= 3'h1;
            end else if (busy_r && tcnt_r == rii_pkg::T_DM_WR) begin
                word_sel_r <= {word_sel_r[1:0], word_sel_r[2]};
            end
            az_r <= std && !drng_r;
            rg_r <= std && drng_r;
        end
    end

    // memory strobe monitors
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_stb_r <= 1'b0;
            wr_stb_r <= 1'b0;
        end else begin
            rd_stb_r <= rd_now;
            wr_stb_r <= wr_int || wr_si || wr_dm || wr_pr;
        end
    end

    // character generator line decode
    generate
        for (genvar g = 0; g < rii_pkg::CHARS; g++) begin : g_char
            always_ff @(posedge clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    char_sel_r[g] <= 1'b0;
                end else begin
                    char_sel_r[g] <= pr_valid_r &&
                                     hold_r == 4'(g);
                end
            end
        end
    endgenerate

    // avalon slave: one wait cycle, then acknowledge
    assign bus_ack = (avs_read_i || avs_write_i) && !wait_r;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_r <= 1'b1;
            rdata_r <= '0;
        end else begin
            wait_r <= !((avs_read_i || avs_write_i) && wait_r);
            if (avs_read_i && wait_r) begin
                case (avs_address_i)
                    rii_pkg::REG_CTRL: rdata_r <= {28'h0, drng_r,
                                                   dpend_r, rate_r, run_r};
                    rii_pkg::REG_DIM: rdata_r <= {16'h0, units_r, tens_r,
                                                  3'h0, dim_base_r};
                    rii_pkg::REG_STAT: rdata_r <= {17'h0, inhibit_r,
                                                   busy_r, sweeps_r,
                                                   3'h0, phase_r};
                    rii_pkg::REG_DISP: rdata_r <= {19'h0, disp_ptr_r,
                                                   disp_mem[disp_ptr_r]};
                    default: rdata_r <= '0;
                endcase
            end
        end
    end

    // control registers
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_r <= 1'b0;
            rate_r <= 1'b0;
            dpend_r <= 1'b0;
            drng_r <= 1'b0;
            dim_base_r <= '0;
            tens_r <= '0;
            units_r <= '0;
            disp_ptr_r <= '0;
        end else begin
            if (bus_ack && avs_write_i &&
                avs_address_i == rii_pkg::REG_CTRL) begin
                run_r <= avs_writedata_i[rii_pkg::C_RUN];
                rate_r <= avs_writedata_i[rii_pkg::C_RATE];
                drng_r <= avs_writedata_i[rii_pkg::C_DRNG];
            end
            if (bus_ack && avs_write_i &&
                avs_address_i == rii_pkg::REG_CTRL &&
                avs_writedata_i[rii_pkg::C_DPEND]) begin
                dpend_r <= 1'b1;
            end else if (pass_end && std) begin
                dpend_r <= 1'b0;
            end
            if (bus_ack && avs_write_i &&
                avs_address_i == rii_pkg::REG_DIM) begin
                dim_base_r <= avs_writedata_i[4:0];
                tens_r <= avs_writedata_i[11:8];
                units_r <= avs_writedata_i[15:12];
            end
            if (bus_ack && avs_write_i &&
                avs_address_i == rii_pkg::REG_DISP) begin
                disp_ptr_r <= avs_writedata_i[12:8];
            end
        end
    end

    assign avs_readdata_o = rdata_r;
    assign avs_waitrequest_o = wait_r;
    assign azimuth_sel_o = az_r;
    assign range_sel_o = rg_r;
    assign word_sel_o = word_sel_r;
    assign advance_o = advance_r;
    assign memory_read_strobe_o = rd_stb_r;
    assign memory_write_strobe_o = wr_stb_r;
    assign char_sel_o = char_sel_r;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_acc_clear;
        busy_r && integ && tcnt_r == rii_pkg::T_RST |=> acc_r == 8'h00;
    endproperty
    a_acc_clear: assert property (p_acc_clear)
        else $error("accumulator not cleared");

    property p_first_zero;
        busy_r && integ && first_r && tcnt_r == rii_pkg::T_LOAD
            |=> fetch_r == 8'h00;
    endproperty
    a_first_zero: assert property (p_first_zero)
        else $error("first sweep sum not zero");

    property p_add;
        busy_r && integ && tcnt_r == rii_pkg::T_ADD
            |=> acc_r == $past(fetch_r) + {4'h0, $past(lvl_r)};
    endproperty
    a_add: assert property (p_add)
        else $error("bad sum");

    property p_writeback;
        wr_int |=> integ_mem[$past(slot_r)] == $past(acc_r);
    endproperty
    a_writeback: assert property (p_writeback)
        else $error("sum not written back");

    property p_avg;
        wr_si |=> disp_mem[$past(slot_r)][7:4] == $past(avg);
    endproperty
    a_avg: assert property (p_avg)
        else $error("average not stored");

    property p_inhibit;
        busy_r && sti && inhibit_r && tcnt_r == rii_pkg::T_SI_WR
            |=> disp_mem[$past(slot_r)] == $past(keep_word);
    endproperty
    a_inhibit: assert property (p_inhibit)
        else $error("flagged word overwritten");

    property p_advance;
        busy_r && std && tcnt_r == rii_pkg::T_DM_WR |=> advance_r &&
            word_sel_r == {$past(word_sel_r[1:0]), $past(word_sel_r[2])};
    endproperty
    a_advance: assert property (p_advance)
        else $error("word select did not advance");

    property p_char;
        pr_valid_r |=> $onehot(char_sel_r);
    endproperty
    a_char: assert property (p_char)
        else $error("character select not one-hot");

    property p_tcnt;
        busy_r && last_cnt && run_r |=> tcnt_r == 5'h00;
    endproperty
    a_tcnt: assert property (p_tcnt)
        else $error("timing counter did not restart");

    property p_wait;
        (avs_read_i || avs_write_i) && wait_r |=> !wait_r ##1 wait_r;
    endproperty
    a_wait: assert property (p_wait)
        else $error("bus answer timing wrong");

    c_store: cover property (wr_si);
    c_inhibit: cover property (busy_r && sti && inhibit_r);
    c_dim: cover property (pass_end && std);
    c_print: cover property (wr_pr);

endmodule // rii_top

//--- core/rii_pkg.sv
package rii_pkg;
    // memory geometry
    localparam int SLOTS = 32;
    localparam int THRESH = 10;
    localparam int CHARS = 16;
    localparam logic [4:0] SLOT_LAST = 5'h1f;
    localparam logic [4:0] DIM_LAST = 5'h02;
    // word layout
    localparam int B_PRINTED = 0;
    localparam int B_DIM = 1;
    localparam logic [1:0] FLAGS_DIM = 2'h2;
    localparam logic [1:0] UNUSED_BITS = 2'h0;
    localparam logic [3:0] LETTER_AZ = 4'ha;
    localparam logic [3:0] LETTER_RG = 4'hb;
    // memory timing counts
    localparam logic [4:0] T_LAST = 5'h13;
    localparam logic [4:0] T_RST = 5'h01;
    localparam logic [4:0] T_LOAD = 5'h02;
    localparam logic [4:0] T_ADD = 5'h03;
    localparam logic [4:0] T_IWR = 5'h04;
    localparam logic [4:0] T_RD = 5'h02;
    localparam logic [4:0] T_SI_SAMP = 5'h04;
    localparam logic [4:0] T_SI_FETCH = 5'h06;
    localparam logic [4:0] T_SI_WR = 5'h0d;
    localparam logic [4:0] T_DM_SAMP = 5'h06;
    localparam logic [4:0] T_DM_WR = 5'h08;
    localparam logic [4:0] T_PR_LOAD = 5'h04;
    localparam logic [4:0] T_PR_MARK = 5'h08;
    // sweeps per integration
    localparam logic [4:0] SWEEPS_LOW = 5'h08;
    localparam logic [4:0] SWEEPS_HIGH = 5'h10;
    // register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_DIM = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    localparam logic [3:0] REG_DISP = 4'hc;
    // control bits
    localparam int C_RUN = 0;
    localparam int C_RATE = 1;
    localparam int C_DPEND = 2;
    localparam int C_DRNG = 3;
    typedef enum logic [4:0] {
        PH_IDLE = 5'b00001,
        PH_INTEG = 5'b00010,
        PH_STI = 5'b00100,
        PH_STD = 5'b01000,
        PH_PRINT = 5'b10000
    } rii_phase_e;
endpackage

//--- sim/rii_radar_model.sv
`timescale 1ns/10ps
module rii_radar_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // bench control
    input wire logic fire_i,
    input wire logic [3:0] level_i,
    // radar pins
    output logic sweep_o,
    output logic [9:0] thresh_hit_o
);
    logic [2:0] width_r;
    // every threshold up to the level is exceeded
    always_comb begin
        for (int i = 0; i < 10; i++) begin
            thresh_hit_o[i] = (i < 32'(level_i));
        end
    end
    // pulse wide enough for the pin synchroniser
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            width_r <= 3'h0;
        end else if (fire_i) begin
            width_r <= 3'h4;
        end else if (width_r != 3'h0) begin
            width_r <= width_r - 3'h1;
        end
    end
    assign sweep_o = (width_r != 3'h0);
endmodule // rii_radar_model

//--- sim/radar_intensity_integrator_tb.sv
`timescale 1ns/10ps
module radar_intensity_integrator_tb;
    logic clk_i, arst_n_i, avs_read_i, avs_write_i, avs_waitrequest_o;
    logic [3:0] avs_address_i, level;
    logic [31:0] avs_writedata_i, avs_readdata_o, q;
    logic sweep_i, azimuth_sel_o, range_sel_o, advance_o, fire;
    logic memory_read_strobe_o, memory_write_strobe_o, az_seen, rg_seen;
    logic [9:0] thresh_hit_i;
    logic [2:0] word_sel_o, sel_seen;
    logic [15:0] char_sel_o, chars_seen;
    logic [3:0] lv [18];
    logic [7:0] w5, t, u;
    int num_errors = 0, n_compared = 0, cycles = 0, advances = 0;
    int n_wr = 0, n_rd = 0;

    rii_top dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .sweep_i(sweep_i),
        .thresh_hit_i(thresh_hit_i), .azimuth_sel_o(azimuth_sel_o),
        .range_sel_o(range_sel_o), .word_sel_o(word_sel_o),
        .advance_o(advance_o), .memory_read_strobe_o(memory_read_strobe_o),
        .memory_write_strobe_o(memory_write_strobe_o),
        .char_sel_o(char_sel_o));
    rii_radar_model model_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .fire_i(fire), .level_i(level), .sweep_o(sweep_i),
        .thresh_hit_o(thresh_hit_i));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        avs_address_i <= a;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        avs_writedata_i <= d;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic rd_disp(input logic [4:0] p, output logic [7:0] w);
        bus(1'b1, rii_pkg::REG_DISP, {19'h0, p, 8'h0});
        bus(1'b0, rii_pkg::REG_DISP, 32'h0);
        w = q[7:0];
    endtask

    task automatic run_pass(input int n);
        chars_seen = 16'h0;
        advances = 0;
        n_wr = 0;
        n_rd = 0;
        sel_seen = 3'h0;
        az_seen = 1'b0;
        rg_seen = 1'b0;
        for (int i = 0; i < n; i++) begin
            lv[i] = 4'(1 + $urandom % 10);
            level <= lv[i];
            fire <= 1'b1;
            @(posedge clk_i);
            fire <= 1'b0;
            repeat (800) @(posedge clk_i);
        end
    endtask

    function automatic logic [3:0] avg(input int n, input logic rate);
        logic [7:0] s;
        s = 8'h0;
        for (int i = 0; i < n - 2; i++) s = s + 8'(lv[i]);
        return rate ? s[7:4] : s[6:3];
    endfunction

    task automatic reset_dut();
        arst_n_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
    endtask

    always @(negedge clk_i) begin
        if (char_sel_o !== 16'h0) begin
            chars_seen = chars_seen | char_sel_o;
            chk("char one-hot", 32'($onehot(char_sel_o)), 32'h1);
        end
        if (advance_o === 1'b1) advances++;
        if (memory_write_strobe_o === 1'b1) n_wr++;
        if (memory_read_strobe_o === 1'b1) n_rd++;
        if (azimuth_sel_o === 1'b1 || range_sel_o === 1'b1) begin
            sel_seen = sel_seen | word_sel_o;
        end else begin
            chk("word sel idle", 32'(word_sel_o), 32'h1);
        end
        if (azimuth_sel_o === 1'b1) az_seen = 1'b1;
        if (range_sel_o === 1'b1) rg_seen = 1'b1;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 70000) begin
            num_errors++;
            wrap_up();
        end
    end

    initial begin
        arst_n_i = 1'b0;
        {avs_read_i, avs_write_i, fire} = 3'h0;
        avs_address_i = 4'h0;
        avs_writedata_i = 32'h0;
        level = 4'h0;
        void'($urandom(2747));
        @(posedge clk_i);
        reset_dut();
        bus(1'b0, rii_pkg::REG_STAT, 32'h0);
        chk("stat idle", q, 32'h1);
        bus(1'b0, 4'h2, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(1'b1, rii_pkg::REG_DIM, 32'hffff_ffff);
        bus(1'b0, rii_pkg::REG_DIM, 32'h0);
        chk("dim reg", q, 32'h0000_ff1f);
        $display("test registers done");
        bus(1'b1, rii_pkg::REG_CTRL, 32'h1);
        run_pass(10);
        rd_disp(5'h05, w5);
        chk("avg low", 32'(w5), {24'h0, avg(10, 1'b0), 4'h1});
        chk("char line", 32'(chars_seen[avg(10, 1'b0)]), 32'h1);
        chk("writes low", n_wr, (8 + 2) * rii_pkg::SLOTS);
        chk("reads low", n_rd, (8 + 3) * rii_pkg::SLOTS);
        $display("test low rate done");
        reset_dut();
        t = 8'($urandom % 10);
        u = 8'($urandom % 10);
        bus(1'b1, rii_pkg::REG_DIM, {16'h0, u[3:0], t[3:0], 8'd20});
        bus(1'b1, rii_pkg::REG_CTRL, 32'hf);
        run_pass(18);
        rd_disp(5'h05, w5);
        chk("avg high", 32'(w5), {24'h0, avg(18, 1'b1), 4'h1});
        rd_disp(5'd20, q[7:0]);
        chk("letter", 32'(q[7:0]), 32'hb3);
        rd_disp(5'd21, q[7:0]);
        chk("tens", 32'(q[7:0]), {24'h0, t[3:0], 4'h3});
        rd_disp(5'd22, q[7:0]);
        chk("units", 32'(q[7:0]), {24'h0, u[3:0], 4'h3});
        chk("advances", advances, 3);
        chk("range sel", {az_seen, rg_seen}, 32'h1);
        chk("word sels", 32'(sel_seen), 32'h7);
        chk("writes high", n_wr, 18 * rii_pkg::SLOTS + 3);
        chk("reads high", n_rd, 19 * rii_pkg::SLOTS + 3);
        $display("test high rate dimension done");
        bus(1'b1, rii_pkg::REG_CTRL, 32'h0);
        bus(1'b1, rii_pkg::REG_DIM, {16'h0, ~u[3:0], ~t[3:0], 8'd20});
        bus(1'b1, rii_pkg::REG_CTRL, 32'h7);
        run_pass(18);
        rd_disp(5'h05, q[7:0]);
        chk("kept intensity", 32'(q[7:0]), 32'(w5));
        rd_disp(5'd21, q[7:0]);
        chk("kept tens", 32'(q[7:0]), {24'h0, t[3:0], 4'h3});
        chk("azimuth sel", {az_seen, rg_seen}, 32'h2);
        chk("writes kept", n_wr, 17 * rii_pkg::SLOTS);
        chk("reads kept", n_rd, 18 * rii_pkg::SLOTS + 3);
        $display("test priority done");
        wrap_up();
    end
endmodule // radar_intensity_integrator_tb
